// [trim_ctrl_defines.vh]
// Contract
// [RL1] test pattern mode replaces all bus data and over-range flags
// [RL2] pattern identical in interleaved and non-interleaved mode
// [RL3] each port gets its own 12-bit word alternating with its complement
// [RL4] powered-down channel does not output the test pattern
// [RL5] demux pattern: two words, two swapped words, one quiet word
// [RL6] non-demux pattern: quiet, full, quiet, full, quiet, flags follow
// [RL7] trigger_stamp_enable puts trigger state in lsb of all four buses
// [RL8] upper 11 bits carry data; trigger bit has same pipeline latency
// [RL9] trigger arrives on out_clock_reset_in, may be asynchronous
// [RL10] same calibration procedure for power-on, pin or control bit
// [RL11] calibration starts only after low then high minimum durations
// [RL12] pin ORed with control bit in extended mode; both must drop
// [RL13] trim_running high for the whole calibration
// [RL14] power-on calibration waits short or long delay by select pin
// [RL15] toggling trim_delay_select while powered may start calibration
// [RL16] request high at power-on skips power-on calibration
// [RL17] controller holds request high across delay toggle before power-up
// [RL18] controller recalibrates after power-up and large changes
// [RL19] controller avoids control access and clock reset during calibration
// [RL20] trim_sequence_select chooses resistor trim plus linearity or linearity
// [RL21] outputs low during calibration; valid 60 cycles after running falls
// [RL22] pattern advances per word, restarts on entering test mode
// [RL23] trigger passes two synchroniser stages before the data pipeline
`ifndef TRIM_CTRL_DEFINES_VH
`define TRIM_CTRL_DEFINES_VH
`define PAT_Q_WORD 12'h008
`define PAT_I_WORD 12'h010
`define PAT_LEN 3'h5
`define CAL_LOW_MIN 16'h0500
`define CAL_HIGH_MIN 16'h0500
`define CAL_DLY_SHORT 32'h0100_0000
`define CAL_DLY_LONG 32'h4000_0000
`define CAL_RES_CYC 32'h0000_8000
`define CAL_LIN_CYC 32'h0001_0000
`define FLUSH_CYC 8'h3C
`define PIPE_LAT 2
`endif

// [word_skid.v]
`timescale 1ns/1ps
module word_skid #(
  parameter W = 52
) (
  input wire ref_clk,
  input wire srst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  // ----------------------------------------
  // two-entry buffer
  // ----------------------------------------
  reg [W-1:0] mem_q [0:1];
  reg wr_q;
  reg rd_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge ref_clk) begin
    if (srst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      if (push & ~pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule

// [adc_test_pattern_timestamp_cal_ctrl.v]
`timescale 1ns/1ps
`include "trim_ctrl_defines.vh"
module adc_test_pattern_timestamp_cal_ctrl #(
  parameter [15:0] LOW_MIN = `CAL_LOW_MIN,
  parameter [15:0] HIGH_MIN = `CAL_HIGH_MIN,
  parameter [31:0] DLY_SHORT = `CAL_DLY_SHORT,
  parameter [31:0] DLY_LONG = `CAL_DLY_LONG,
  parameter [31:0] RES_CYC = `CAL_RES_CYC,
  parameter [31:0] LIN_CYC = `CAL_LIN_CYC
) (
  input wire ref_clk,
  input wire srst,
  input wire [11:0] q_conv_in,
  input wire [11:0] i_conv_in,
  input wire [11:0] q_conv_early_in,
  input wire [11:0] i_conv_early_in,
  input wire q_range_in,
  input wire i_range_in,
  input wire word_strobe,
  input wire test_pattern_en,
  input wire demux_mode,
  input wire interleaved_mode,
  input wire q_power_down,
  input wire i_power_down,
  input wire trigger_stamp_enable,
  input wire out_clock_reset_in,
  input wire trim_request,
  input wire trim_request_bit,
  input wire extended_control_mode,
  input wire trim_delay_select,
  input wire trim_sequence_select,
  input wire rx_ready,
  output reg [11:0] q_delayed_bus,
  output reg [11:0] i_delayed_bus,
  output reg [11:0] q_bus_main,
  output reg [11:0] i_bus_main,
  output reg q_overrange_flag,
  output reg i_overrange_flag,
  output reg out_valid,
  output reg trim_running,
  output reg trim_resistor_phase,
  output reg data_valid
);
  // ----------------------------------------
  // state encoding
  // ----------------------------------------
  localparam [4:0] S_PWR = 5'h01;
  localparam [4:0] S_IDLE = 5'h02;
  localparam [4:0] S_RES = 5'h04;
  localparam [4:0] S_LIN = 5'h08;
  localparam [4:0] S_FLUSH = 5'h10;

  function [23:0] pat_pair;
    input [11:0] w;
    input full;
    begin
      pat_pair = full ? {~w, w} : {w, w};
    end
  endfunction

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg trig_s1_q;
  reg trig_s2_q;
  reg req_s1_q;
  reg req_s2_q;
  reg dly_s1_q;
  reg dly_s2_q;
  reg dly_last_q;
  always @(posedge ref_clk) begin
    if (srst) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      dly_s1_q <= 1'b0;
      dly_s2_q <= 1'b0;
    end else begin
      trig_s1_q <= out_clock_reset_in; // RL9
      trig_s2_q <= trig_s1_q; // RL23
      req_s1_q <= trim_request;
      req_s2_q <= req_s1_q;
      dly_s1_q <= trim_delay_select;
      dly_s2_q <= dly_s1_q;
    end
  end

  wire req_comb = req_s2_q | (extended_control_mode & trim_request_bit); // RL12

  // ----------------------------------------
  // calibration sequencer
  // ----------------------------------------
  reg [4:0] st_q;
  reg [31:0] cnt_q;
  reg [15:0] lo_q;
  reg [15:0] hi_q;
  reg armed_q;
  reg boot_q;
  reg [4:0] st_d;
  reg [31:0] cnt_d;
  wire dly_toggle = ~boot_q & (dly_s2_q != dly_last_q);
  wire cmd_go = armed_q & (hi_q >= HIGH_MIN); // RL11
  wire [31:0] pwr_dly = dly_s2_q ? DLY_LONG : DLY_SHORT; // RL14
  wire [31:0] first_len = trim_sequence_select ? RES_CYC : LIN_CYC;

  always @* begin
    st_d = st_q;
    cnt_d = cnt_q + 32'h1;
    case (st_q)
      S_PWR: begin
        if (!boot_q && req_comb) begin
          st_d = S_IDLE; // RL16
          cnt_d = 32'h0;
        end else if (!boot_q && cnt_q >= pwr_dly) begin
          st_d = trim_sequence_select ? S_RES : S_LIN; // RL10
          cnt_d = 32'h0;
        end
      end
      S_IDLE: begin
        cnt_d = 32'h0;
        if (cmd_go || dly_toggle) // RL15
          st_d = trim_sequence_select ? S_RES : S_LIN; // RL20
      end
      S_RES: begin
        if (cnt_q >= first_len - 32'h1) begin
          st_d = S_LIN;
          cnt_d = 32'h0;
        end
      end
      S_LIN: begin
        if (cnt_q >= LIN_CYC - 32'h1) begin
          st_d = S_FLUSH;
          cnt_d = 32'h0;
        end
      end
      S_FLUSH: begin
        if (cnt_q >= {24'h0, `FLUSH_CYC} - 32'h1) begin
          st_d = S_IDLE; // RL21
          cnt_d = 32'h0;
        end
      end
      default: begin
        st_d = S_IDLE;
        cnt_d = 32'h0;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      st_q <= S_PWR;
      cnt_q <= 32'h0;
      lo_q <= 16'h0;
      hi_q <= 16'h0;
      armed_q <= 1'b0;
      boot_q <= 1'b1;
      dly_last_q <= 1'b0;
      trim_running <= 1'b0;
      trim_resistor_phase <= 1'b0;
      data_valid <= 1'b0;
    end else begin
      boot_q <= 1'b0;
      dly_last_q <= dly_s2_q;
      st_q <= st_d;
      cnt_q <= cnt_d;
      if (req_comb) begin
        lo_q <= 16'h0;
        if (hi_q != 16'hFFFF)
          hi_q <= hi_q + 16'h1;
      end else begin
        hi_q <= 16'h0;
        armed_q <= armed_q | (lo_q >= LOW_MIN);
        if (lo_q != 16'hFFFF)
          lo_q <= lo_q + 16'h1;
      end
      if ((st_q == S_IDLE) && cmd_go)
        armed_q <= 1'b0; // RL12
      trim_running <= (st_d == S_RES) | (st_d == S_LIN); // RL13
      trim_resistor_phase <= (st_d == S_RES);
      data_valid <= (st_d == S_IDLE); // RL21
    end
  end

  // ----------------------------------------
  // pattern generator
  // ----------------------------------------
  reg [2:0] pidx_q;
  reg tp_last_q;
  wire tp_start = test_pattern_en & ~tp_last_q;
  always @(posedge ref_clk) begin
    if (srst) begin
      pidx_q <= 3'h0;
      tp_last_q <= 1'b0;
    end else begin
      tp_last_q <= test_pattern_en;
      if (tp_start)
        pidx_q <= 3'h0; // RL22
      else if (word_strobe)
        pidx_q <= (pidx_q == `PAT_LEN - 3'h1) ? 3'h0 : pidx_q + 3'h1;
    end
  end

  // demux: 0,1 delayed full; 2,3 main full; 4 quiet
  wire dm_dly_full = (pidx_q == 3'h0) | (pidx_q == 3'h1); // RL5
  wire dm_main_full = (pidx_q == 3'h2) | (pidx_q == 3'h3);
  wire nd_full = (pidx_q == 3'h1) | (pidx_q == 3'h3); // RL6
  wire [23:0] q_pair_d = pat_pair(`PAT_Q_WORD, dm_dly_full);
  wire [23:0] i_pair_d = pat_pair(`PAT_I_WORD, dm_dly_full);
  wire m_full = demux_mode ? dm_main_full : nd_full;
  wire [23:0] q_pair_m = pat_pair(`PAT_Q_WORD, m_full); // RL3
  wire [23:0] i_pair_m = pat_pair(`PAT_I_WORD, m_full);
  wire pat_flag = demux_mode ? (pidx_q != 3'h4) : nd_full;

  // ----------------------------------------
  // data path with trigger stamp
  // ----------------------------------------
  reg [49:0] pipe_q [0:`PIPE_LAT-1];
  reg [49:0] sel_d;
  wire [49:0] conv_word = {q_range_in, i_range_in, q_conv_early_in,
    i_conv_early_in, q_conv_in, i_conv_in};
  always @* begin
    sel_d = conv_word;
    if (trigger_stamp_enable) begin
      sel_d[36] = trig_s2_q; // RL7
      sel_d[24] = trig_s2_q;
      sel_d[12] = trig_s2_q;
      sel_d[0] = trig_s2_q; // RL8
    end
    if (test_pattern_en) begin
      // interleaved_mode does not change the pattern
      sel_d = {pat_flag, pat_flag, q_pair_d[23:12], i_pair_d[23:12],
        q_pair_m[23:12], i_pair_m[23:12]}; // RL1 RL2
      if (q_power_down) begin
        sel_d[49] = 1'b0; // RL4
        sel_d[47:36] = 12'h000;
        sel_d[23:12] = 12'h000;
      end
      if (i_power_down) begin
        sel_d[48] = 1'b0;
        sel_d[35:24] = 12'h000;
        sel_d[11:0] = 12'h000;
      end
    end
    if (!data_valid)
      sel_d = 50'h0; // RL21
  end

  genvar g;
  generate
    for (g = 0; g < `PIPE_LAT; g = g + 1) begin : stage
      always @(posedge ref_clk) begin
        if (srst)
          pipe_q[g] <= 50'h0;
        else if (word_strobe)
          pipe_q[g] <= (g == 0) ? sel_d : pipe_q[(g == 0) ? 0 : g - 1]; // RL8
      end
    end
  endgenerate

  // ----------------------------------------
  // output buffer
  // ----------------------------------------
  wire buf_in_ready;
  wire buf_valid;
  wire [49:0] buf_data;
  reg push_q;
  always @(posedge ref_clk) begin
    if (srst)
      push_q <= 1'b0;
    else
      push_q <= word_strobe;
  end

  word_skid #(
    .W(50)
  ) u_skid (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(push_q),
    .in_ready(buf_in_ready),
    .in_data(pipe_q[`PIPE_LAT-1]),
    .out_valid(buf_valid),
    .out_ready(rx_ready),
    .out_data(buf_data)
  );

  always @(posedge ref_clk) begin
    if (srst) begin
      q_overrange_flag <= 1'b0;
      i_overrange_flag <= 1'b0;
      q_delayed_bus <= 12'h000;
      i_delayed_bus <= 12'h000;
      q_bus_main <= 12'h000;
      i_bus_main <= 12'h000;
      out_valid <= 1'b0;
    end else begin
      out_valid <= buf_valid & rx_ready;
      if (!data_valid) begin
        q_overrange_flag <= 1'b0; // RL21
        i_overrange_flag <= 1'b0;
        q_delayed_bus <= 12'h000;
        i_delayed_bus <= 12'h000;
        q_bus_main <= 12'h000;
        i_bus_main <= 12'h000;
      end else if (buf_valid & rx_ready) begin
        q_overrange_flag <= buf_data[49];
        i_overrange_flag <= buf_data[48];
        q_delayed_bus <= buf_data[47:36];
        i_delayed_bus <= buf_data[35:24];
        q_bus_main <= buf_data[23:12];
        i_bus_main <= buf_data[11:0];
      end
    end
  end
endmodule

// [trim_ctrl_checker.sv]
`timescale 1ns/1ps
module trim_ctrl_checker (
  input wire ref_clk,
  input wire srst,
  input wire test_pattern_en,
  input wire demux_mode,
  input wire q_power_down,
  input wire i_power_down,
  input wire [11:0] q_delayed_bus,
  input wire [11:0] i_delayed_bus,
  input wire [11:0] q_bus_main,
  input wire [11:0] i_bus_main,
  input wire q_overrange_flag,
  input wire i_overrange_flag,
  input wire out_valid,
  input wire trim_running,
  input wire trim_resistor_phase,
  input wire data_valid
);
  // ------------------------------
  // settle and flush counters
  // ------------------------------
  logic [3:0] cfg_q;
  logic [5:0] st_q;
  logic [6:0] fl_q;
  logic ran_q;
  wire [3:0] cfg = {test_pattern_en, demux_mode, q_power_down, i_power_down};
  wire [49:0] outs = {q_overrange_flag, i_overrange_flag, q_delayed_bus,
    i_delayed_bus, q_bus_main, i_bus_main};
  always @(posedge ref_clk) begin
    cfg_q <= cfg;
    st_q <= (srst || cfg != cfg_q) ? 6'h00 : st_q + {5'h00, st_q != 6'h3F};
    fl_q <= (srst || trim_running) ? 7'h00 : fl_q + {6'h00, fl_q != 7'h7F};
    ran_q <= !srst && (ran_q || trim_running);
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_run;
    trim_running && $past(trim_running);
  endsequence
  sequence s_pat;
    out_valid && st_q == 6'h3F && test_pattern_en && data_valid;
  endsequence
  sequence s_both;
    s_pat ##0 !q_power_down && !i_power_down;
  endsequence
  AST_CAL_QUIET: assert property (s_run |-> outs == 50'h0)
    else $error("outputs active in calibration");
  AST_RUN_NO_VALID: assert property (s_run |-> !data_valid)
    else $error("data valid in calibration");
  AST_FLUSH: assert property (
    $rose(data_valid) && ran_q |-> fl_q >= 7'h3B && fl_q <= 7'h3E)
    else $error("flush length wrong");
  AST_RES_IN_RUN: assert property (
    trim_resistor_phase |-> trim_running)
    else $error("resistor phase outside run");
  AST_PAT_WORDS: assert property (s_both |->
    (q_bus_main == 12'h008 || q_bus_main == 12'hFF7) &&
    (i_bus_main == 12'h010 || i_bus_main == 12'hFEF))
    else $error("pattern word wrong");
  AST_PAT_NDM: assert property (s_both ##0 !demux_mode |->
    q_overrange_flag == (q_bus_main == 12'hFF7) &&
    i_overrange_flag == (i_bus_main == 12'hFEF))
    else $error("plain mode flag wrong");
  AST_PAT_DM: assert property (s_both ##0 demux_mode |->
    q_overrange_flag == (q_delayed_bus != q_bus_main) &&
    (q_delayed_bus == ~q_bus_main || q_delayed_bus == q_bus_main))
    else $error("demux pattern wrong");
  AST_PD_QUIET: assert property (s_pat ##0 q_power_down |->
    !q_overrange_flag && q_bus_main == 12'h000 && q_delayed_bus == 12'h000)
    else $error("powered down channel active");
endmodule
bind adc_test_pattern_timestamp_cal_ctrl trim_ctrl_checker chk (.*);

// [adc_rx_model.sv]
`timescale 1ns/1ps
module adc_rx_model (
  input wire ref_clk,
  input wire out_valid,
  input wire [49:0] bus_w,
  input wire stall_en,
  output logic rx_ready,
  output logic [49:0] cap_w,
  output int cap_n
);
  // ------------------------------
  // receiver with periodic stalls
  // ------------------------------
  logic [2:0] ph_q = 3'h0;
  initial begin
    rx_ready = 1'b1;
    cap_w = 50'h0;
    cap_n = 0;
  end
  always @(posedge ref_clk) begin
    ph_q <= ph_q + 3'h1;
    rx_ready <= #1 !(stall_en && ph_q < 3'h3);
    if (out_valid) begin
      cap_w <= bus_w;
      cap_n <= cap_n + 1;
    end
  end
endmodule

// [adc_test_pattern_timestamp_cal_ctrl_test.sv]
`timescale 1ns/1ps
module adc_test_pattern_timestamp_cal_ctrl_test;
  // ------------------------------
  // stimulus, checks and sequence
  // ------------------------------
  logic ref_clk = 0, srst = 1, word_strobe = 0, sto = 1, lclk = 0, lrun = 0;
  logic [11:0] q_conv_in = 0, i_conv_in = 0;
  logic [11:0] q_conv_early_in = 0, i_conv_early_in = 0;
  logic test_pattern_en = 0, demux_mode = 0, interleaved_mode = 0;
  logic q_power_down = 0, i_power_down = 0, trigger_stamp_enable = 0;
  logic trim_request = 0, trim_request_bit = 0, extended_control_mode = 0;
  logic trim_delay_select = 0, trim_sequence_select = 1, trig = 0, stall = 0;
  logic [2:0] sc = 0;
  logic [49:0] w [10];
  logic [49:0] e, m, z;
  logic hit, t;
  wire [11:0] q_delayed_bus, i_delayed_bus, q_bus_main, i_bus_main;
  wire q_overrange_flag, i_overrange_flag, out_valid, trim_running;
  wire trim_resistor_phase, data_valid, rx_ready;
  wire q_range_in = q_conv_in[0];
  wire i_range_in = i_conv_in[0];
  wire out_clock_reset_in = lrun ? lclk : trig;
  wire [49:0] cap;
  int cap_n, bad_count = 0, n_tests = 0, seed = 50, k, r, n;
  adc_test_pattern_timestamp_cal_ctrl #(.LOW_MIN(16'h0004),
    .HIGH_MIN(16'h0004), .DLY_SHORT(32'h32), .DLY_LONG(32'h64),
    .RES_CYC(32'h14), .LIN_CYC(32'h14)) DUT (.*);
  adc_rx_model rx (.ref_clk, .out_valid, .stall_en(stall), .rx_ready,
    .bus_w({q_overrange_flag, i_overrange_flag, q_delayed_bus,
    i_delayed_bus, q_bus_main, i_bus_main}), .cap_w(cap), .cap_n);
  initial forever #4 ref_clk = ~ref_clk;
  initial begin
    #3.3;
    forever #32 lclk = ~lclk;
  end
  always @(posedge ref_clk) begin
    sc <= (sc == 3'h5) ? 3'h0 : sc + 3'h1;
    word_strobe <= #1 sto && sc == 3'h0;
  end
  task wrap_up;
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [49:0] x, input logic [49:0] s);
    n_tests++;
    if (x !== s) begin
      $display("BAD %s exp %h got %h", nm, x, s);
      bad_count++;
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task wrun(input logic lv, input logic sel, input int lim, input logic mu);
    n = 0;
    while ((sel ? data_valid : trim_running) !== lv && n < lim) begin
      cyc(1);
      n++;
    end
    if (mu && n == lim) begin
      bad_count++;
      wrap_up();
    end
  endtask
  task rst(input logic ds, input logic rq);
    srst = 1;
    trim_delay_select = ds;
    trim_request = rq;
    cyc(2);
    srst = 0;
  endtask
  task pulse(input int hi);
    cyc(10);
    trim_request = 1;
    if (hi > 0) begin
      cyc(hi);
      trim_request = 0;
    end
  endtask
  task cal_cycle(input logic er, input int ln);
    int c;
    logic sr;
    c = 0;
    sr = 0;
    while (trim_running === 1'b1 && c < 200) begin
      sr |= trim_resistor_phase;
      cyc(1);
      c++;
    end
    chk("res_phase", er, sr);
    chk("run_len", 1, c >= ln - 1 && c <= ln + 4);
    wrun(1, 1, 100, 1);
    chk("flush", 1, n >= 58 && n <= 62);
  endtask
  task get(output logic [49:0] v);
    int c0, c;
    c0 = cap_n;
    c = 0;
    while (cap_n == c0 && c < 100) begin
      cyc(1);
      c++;
    end
    if (c == 100) begin
      bad_count++;
      wrap_up();
    end
    v = cap;
  endtask
  function logic [49:0] pat(input logic dm, input int x);
    logic [23:0] lo;
    lo = {12'h008, 12'h010};
    if (!dm) return (x % 2) ? {2'b11, 24'h0, ~lo} : {2'b00, 24'h0, lo};
    if (x < 2) return {2'b11, ~lo, lo};
    if (x < 4) return {2'b11, lo, ~lo};
    return {2'b00, lo, lo};
  endfunction
  function logic [11:0] st(input logic [11:0] v);
    return trigger_stamp_enable ? {v[11:1], trig} : v;
  endfunction
  initial begin
    rst(0, 0);
    wrun(1, 0, 200, 1);
    chk("po_short", 1, n >= 48 && n <= 58);
    cal_cycle(1, 40);
    rst(1, 0);
    wrun(1, 0, 200, 1);
    chk("po_long", 1, n >= 98 && n <= 108);
    cal_cycle(1, 40);
    rst(0, 1);
    wrun(1, 0, 150, 0);
    chk("po_skip", 150, n);
    trim_request = 0;
    pulse(2);
    wrun(1, 0, 30, 0);
    chk("short_pulse", 30, n);
    pulse(0);
    wrun(1, 0, 30, 1);
    cal_cycle(1, 40);
    trim_request = 0;
    extended_control_mode = 1;
    trim_sequence_select = 0;
    cyc(10);
    trim_request_bit = 1;
    wrun(1, 0, 30, 1);
    cal_cycle(0, 20);
    pulse(10);
    wrun(1, 0, 30, 0);
    chk("or_held", 30, n);
    trim_delay_select = ~trim_delay_select;
    wrun(1, 0, 30, 1);
    cal_cycle(0, 20);
    sto = 1;
    stall = 1;
    for (k = 0; k < 6; k++) begin
      {i_power_down, q_power_down} = {k[2] & k[0], k[2] & ~k[0]};
      {interleaved_mode, demux_mode} = k[1:0];
      test_pattern_en = 1;
      m = demux_mode ? '1 : {2'b11, 24'h0, 24'hFFFFFF};
      z = {q_power_down, i_power_down, {2{{12{q_power_down}},
        {12{i_power_down}}}}};
      cyc(60);
      for (r = 0; r < 10; r++) get(w[r]);
      hit = 0;
      for (r = 0; r < 5; r++) begin
        t = 1;
        for (n = 0; n < 10; n++)
          if ((w[n] & m) !== (pat(demux_mode, (r + n) % 5) & m & ~z)) t = 0;
        hit |= t;
      end
      chk("pattern", 1, hit);
      test_pattern_en = 0;
      cyc(12);
    end
    q_power_down = 0;
    i_power_down = 0;
    for (k = 0; k < 8; k++) begin
      {q_conv_early_in, i_conv_early_in} = 24'($random(seed));
      {q_conv_in, i_conv_in} = 24'($random(seed));
      trigger_stamp_enable = k[2];
      trig = k[0];
      cyc(60);
      get(e);
      chk("stamp", {q_conv_in[0], i_conv_in[0],
        st(q_conv_early_in), st(i_conv_early_in), st(q_conv_in),
        st(i_conv_in)}, e);
    end
    lrun = 1;
    hit = 0;
    t = 0;
    for (r = 0; r < 10; r++) begin
      get(e);
      chk("stamp_lsb", {4{e[0]}}, {e[36], e[24], e[12], e[0]});
      hit |= e[0];
      t |= !e[0];
    end
    chk("stamp_async", 2'b11, {hit, t});
    wrap_up();
  end
endmodule
